// ### rtl/sac_clkdiv.v
// conversion clock tick generator
`default_nettype none
module sac_clkdiv (
  input  wire       sys_clk_i,
  input  wire       reset_i,
  input  wire       run_i,
  input  wire [4:0] div_i,
  output wire       tick_o
);
  // ==========================================================================
  // period counter
  reg  [5:0] cnt_q;
  wire [5:0] limit;

  // D=0 ticks every cycle, else one tick per 2*(D+1) cycles
  assign limit  = (div_i == 5'h00) ? 6'h00 : {div_i, 1'b1}; // (R5) (R6)
  assign tick_o = run_i & (cnt_q == limit);

  always @(posedge sys_clk_i) begin
    if (reset_i || !run_i || tick_o) begin
      cnt_q <= 6'h00;
    end else begin
      cnt_q <= cnt_q + 6'h01;
    end
  end
endmodule // sac_clkdiv
`default_nettype wire

// ### rtl/sac_defs.vh
// register map, field positions, reset values and timing counts of the converter control block
// ==========================================================================
// Overview of operation
// (R1) each pair bit clear gives two single-ended inputs; set joins them, even positive
// (R2) a differential channel yields its result in two's complement form
// (R3) channel code 0000-0111 picks input n, 1xxx the temperature sensor
// (R4) upper four bits of both multiplexer registers read zero, writes ignored
// (R5) nonzero divider D gives conversion clock of system clock over 2*(D+1)
// (R6) divider value zero makes the conversion clock equal the system clock
// (R7) gain code 000=1, 001=2, 010=4, 011=8, 10x=16, 11x=0.5
// (R8) enable clear keeps converter shut down; set makes it active, accepting starts
// (R9) track mode clear and enabled: track continuously except during a conversion
// (R10) completion sets the done flag and holds it; only software clears it
// (R11) busy reads 1 during conversion; done flag set on busy falling edge
// (R12) writing busy 1 starts a conversion only in start mode 00; 0 ignored
// (R13) start mode picks software write, timer 3, pin rising edge, timer 2
// (R14) track mode set, modes 00/01/11: trigger starts 3 clock tracking, then conversion
// (R15) track mode set, mode 10: track while pin low, convert on rising edge
// (R16) window match sets the window flag and holds it; only software clears it
// (R17) justify bit selects right (0) or left (1) justified result bytes
// (R18) right justified: high byte holds upper four bits, bits 7-4 copy bit 3
// (R19) left justified: high byte holds top eight bits; low byte bits 3-0 zero
// (R20) each conversion lasts at least 16 conversion clock periods
// (R21) busy stays 1 for the whole conversion and returns 0 at completion
// (R22) both result bytes update together in the cycle busy falls
`ifndef SAC_DEFS_VH
`define SAC_DEFS_VH

// ==========================================================================
// register indices, byte address is four times the index
`define SAC_IDX_PAIR_CFG     10'h0BA
`define SAC_IDX_CHAN_SEL     10'h0BB
`define SAC_IDX_CONV_CFG     10'h0BC
`define SAC_IDX_RES_LOW      10'h0BE
`define SAC_IDX_RES_HIGH     10'h0BF
`define SAC_IDX_CONV_CTL     10'h0E8

// ==========================================================================
// reset values
`define SAC_RST_PAIR_CFG     4'h0
`define SAC_RST_CHAN_SEL     4'h0
`define SAC_RST_CONV_CFG     8'hF8
`define SAC_RST_RESULT       8'h00

// ==========================================================================
// converter_control field positions
`define SAC_CTL_ON           7
`define SAC_CTL_TRACK        6
`define SAC_CTL_DONE         5
`define SAC_CTL_BUSY         4
`define SAC_CTL_MODE_HI      3
`define SAC_CTL_MODE_LO      2
`define SAC_CTL_WIN          1
`define SAC_CTL_LEFT         0

// start sources
`define SAC_START_SW         2'h0
`define SAC_START_T3         2'h1
`define SAC_START_PIN        2'h2
`define SAC_START_T2         2'h3

// ==========================================================================
// timing in conversion clock periods
`define SAC_TRACK_CLKS       4'h3
`define SAC_CONV_CLKS        5'h10

`endif

// ### rtl/sac_top.v
// converter control block: apb registers, start logic, sequencer and result formatting
//
// Register access over APB is this design's own decision.
`include "sac_defs.vh"
`default_nettype none
module sac_top (
  input  wire        sys_clk_i,
  input  wire        reset_i,
  // apb slave
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [11:0] paddr_i,
  input  wire [31:0] pwdata_i,
  output reg         pready_o,
  output reg  [31:0] prdata_o,
  output reg         pslverr_o,
  // start sources
  input  wire        timer2_ovf_i,
  input  wire        timer3_ovf_i,
  input  wire        external_start_pin_i,
  // analog core
  input  wire [11:0] conv_data_i,
  input  wire        window_match_i,
  output reg         converter_on_o,
  output reg         track_o,
  output reg         convert_o,
  output reg         sar_tick_o,
  output reg  [2:0]  mux_pos_o,
  output reg  [2:0]  mux_neg_o,
  output reg         diff_mode_o,
  output reg         temp_sel_o,
  output reg  [5:0]  gain_sel_o
);

  // ==========================================================================
  // sequencer states
  localparam [2:0] ST_IDLE  = 3'b001;
  localparam [2:0] ST_TRACK = 3'b010;
  localparam [2:0] ST_CONV  = 3'b100;

  // ==========================================================================
  // register storage
  reg  [3:0]  pair_cfg_q;
  reg  [3:0]  channel_code_q;
  reg  [7:0]  conv_cfg_q;
  reg  [7:0]  res_low_q;
  reg  [7:0]  res_high_q;
  reg         on_q;
  reg         track_sel_q;
  reg         done_q;
  reg         busy_q;
  reg  [1:0]  start_sel_q;
  reg         win_q;
  reg         left_q;

  reg  [2:0]  state_q;
  reg  [2:0]  state_d;
  reg  [4:0]  phase_q;
  reg  [4:0]  phase_d;
  reg         pin_prev_q;

  // ==========================================================================
  // apb decode
  wire        access;
  wire        complete;
  wire        aligned;
  wire [9:0]  idx;
  reg         hit;
  reg  [7:0]  rd_d;
  reg  [5:0]  wsel;

  assign access   = psel_i & penable_i;
  // writes land only on the edge where pready is seen high
  assign complete = access & pready_o;
  assign aligned  = (paddr_i[1:0] == 2'h0);
  assign idx      = paddr_i[11:2];

  always @* begin
    hit  = aligned;
    rd_d = 8'h00;
    wsel = 6'h00;
    if (aligned && idx == `SAC_IDX_PAIR_CFG) begin
      rd_d    = {4'h0, pair_cfg_q}; // (R4)
      wsel[0] = 1'b1;
    end else if (aligned && idx == `SAC_IDX_CHAN_SEL) begin
      rd_d    = {4'h0, channel_code_q}; // (R4)
      wsel[1] = 1'b1;
    end else if (aligned && idx == `SAC_IDX_CONV_CFG) begin
      rd_d    = conv_cfg_q;
      wsel[2] = 1'b1;
    end else if (aligned && idx == `SAC_IDX_RES_LOW) begin
      rd_d    = res_low_q;
      wsel[3] = 1'b1;
    end else if (aligned && idx == `SAC_IDX_RES_HIGH) begin
      rd_d    = res_high_q;
      wsel[4] = 1'b1;
    end else if (aligned && idx == `SAC_IDX_CONV_CTL) begin
      rd_d    = {on_q, track_sel_q, done_q, busy_q,
                 start_sel_q, win_q, left_q}; // (R11)
      wsel[5] = 1'b1;
    end else begin
      hit = 1'b0;
    end
  end

  wire        wr_en;
  wire        wr_ctl;
  wire [1:0]  wr_mode;

  assign wr_en   = complete & pwrite_i;
  assign wr_ctl  = wr_en & wsel[5];
  assign wr_mode = pwdata_i[`SAC_CTL_MODE_HI:`SAC_CTL_MODE_LO];

  // one wait state: pready rises in the second access cycle
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      pready_o  <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= access & ~pready_o;
      pslverr_o <= access & ~pready_o & ~hit;
      if (access && !pready_o) begin
        prdata_o <= {24'h00_0000, rd_d};
      end
    end
  end

  // ==========================================================================
  // conversion clock
  wire tick;

  sac_clkdiv u_clkdiv (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .run_i     (state_q != ST_IDLE),
    .div_i     (conv_cfg_q[7:3]),
    .tick_o    (tick)
  );

  // ==========================================================================
  // start sources
  wire       pin_rise;
  wire       sw_start;
  wire       trk_now;
  wire [1:0] src_now;
  reg        trigger;

  assign pin_rise = external_start_pin_i & ~pin_prev_q;
  // a control write counts with the track mode and source it carries
  assign trk_now  = wr_ctl ? pwdata_i[`SAC_CTL_TRACK] : track_sel_q;
  assign src_now  = wr_ctl ? wr_mode : start_sel_q;
  // uses the mode written in the same access, so one write may set mode and start
  assign sw_start = wr_ctl & pwdata_i[`SAC_CTL_BUSY] & (wr_mode == `SAC_START_SW); // (R12)

  always @* begin
    case (src_now) // (R13)
      `SAC_START_SW: trigger = sw_start;
      `SAC_START_T3: trigger = timer3_ovf_i;
      `SAC_START_PIN: trigger = pin_rise;
      default:       trigger = timer2_ovf_i;
    endcase
  end

  // ==========================================================================
  // sequencer
  wire finish;
  wire go_conv;

  assign finish  = (state_q == ST_CONV) && tick &&
                   (phase_q == `SAC_CONV_CLKS - 5'h01); // (R20)
  // pin mode converts at once: the low phase of the pin was the tracking
  assign go_conv = ~trk_now | (src_now == `SAC_START_PIN); // (R15)

  always @* begin
    state_d = state_q;
    phase_d = phase_q;
    case (state_q)
      ST_IDLE: begin
        phase_d = 5'h00;
        if (on_q && trigger) begin // (R8)
          state_d = go_conv ? ST_CONV : ST_TRACK; // (R14)
        end
      end
      ST_TRACK: begin
        if (tick) begin
          phase_d = phase_q + 5'h01;
          if (phase_q == {1'b0, `SAC_TRACK_CLKS} - 5'h01) begin // (R14)
            state_d = ST_CONV;
            phase_d = 5'h00;
          end
        end
      end
      ST_CONV: begin
        if (tick) begin
          phase_d = phase_q + 5'h01;
        end
        if (finish) begin
          state_d = ST_IDLE;
          phase_d = 5'h00;
        end
      end
      default: begin
        state_d = ST_IDLE;
        phase_d = 5'h00;
      end
    endcase
    // shutdown abandons a conversion in flight; one whose last tick falls in the first cycle after the enable clears still loads its result
    if (!on_q) begin // (R8)
      state_d = ST_IDLE;
      phase_d = 5'h00;
    end
  end

  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      state_q    <= ST_IDLE;
      phase_q    <= 5'h00;
      pin_prev_q <= 1'b0;
    end else begin
      state_q    <= state_d;
      phase_q    <= phase_d;
      pin_prev_q <= external_start_pin_i;
    end
  end

  // ==========================================================================
  // result formatting
  wire        sel_diff;
  wire [11:0] result;
  reg  [7:0]  hi_fmt;
  reg  [7:0]  lo_fmt;

  assign sel_diff = ~channel_code_q[3] & pair_cfg_q[channel_code_q[2:1]]; // (R1)
  // core delivers offset binary; flipping the msb gives two's complement
  assign result   = sel_diff ? {~conv_data_i[11], conv_data_i[10:0]} : conv_data_i; // (R2)

  always @* begin
    if (left_q) begin // (R17)
      hi_fmt = result[11:4]; // (R19)
      lo_fmt = {result[3:0], 4'h0}; // (R19)
    end else begin
      hi_fmt = {{4{result[11]}}, result[11:8]}; // (R18)
      lo_fmt = result[7:0]; // (R18)
    end
  end

  // ==========================================================================
  // register writes and hardware updates
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      pair_cfg_q     <= `SAC_RST_PAIR_CFG;
      channel_code_q <= `SAC_RST_CHAN_SEL;
      conv_cfg_q     <= `SAC_RST_CONV_CFG;
      res_low_q      <= `SAC_RST_RESULT;
      res_high_q     <= `SAC_RST_RESULT;
      on_q           <= 1'b0;
      track_sel_q    <= 1'b0;
      done_q         <= 1'b0;
      busy_q         <= 1'b0;
      start_sel_q    <= 2'h0;
      win_q          <= 1'b0;
      left_q         <= 1'b0;
    end else begin
      if (wr_en && wsel[0]) begin
        pair_cfg_q <= pwdata_i[3:0]; // (R4)
      end
      if (wr_en && wsel[1]) begin
        channel_code_q <= pwdata_i[3:0]; // (R4)
      end
      if (wr_en && wsel[2]) begin
        conv_cfg_q <= pwdata_i[7:0];
      end
      // results load together, hardware wins over a software write
      if (finish) begin
        res_low_q  <= lo_fmt; // (R22)
        res_high_q <= hi_fmt; // (R22)
      end else begin
        if (wr_en && wsel[3]) begin
          res_low_q <= pwdata_i[7:0];
        end
        if (wr_en && wsel[4]) begin
          res_high_q <= pwdata_i[7:0];
        end
      end
      if (wr_ctl) begin
        on_q        <= pwdata_i[`SAC_CTL_ON];
        track_sel_q <= pwdata_i[`SAC_CTL_TRACK];
        start_sel_q <= wr_mode;
        left_q      <= pwdata_i[`SAC_CTL_LEFT];
      end
      // flags: a set in the clearing cycle wins
      if (finish) begin
        done_q <= 1'b1; // (R10) (R11)
      end else if (wr_ctl) begin
        done_q <= pwdata_i[`SAC_CTL_DONE];
      end
      if (window_match_i) begin
        win_q <= 1'b1; // (R16)
      end else if (wr_ctl) begin
        win_q <= pwdata_i[`SAC_CTL_WIN];
      end
      // busy is not written directly: 0 has no effect
      busy_q <= (state_d != ST_IDLE); // (R21)
    end
  end

  // ==========================================================================
  // analog core controls
  reg [2:0] pos_d;
  reg [5:0] gain_d;
  wire      track_d;

  always @* begin
    if (sel_diff) begin
      pos_d = {channel_code_q[2:1], 1'b0}; // (R3)
    end else begin
      pos_d = channel_code_q[2:0]; // (R3)
    end
    case (conv_cfg_q[2:0]) // (R7)
      3'h0:    gain_d = 6'h02;
      3'h1:    gain_d = 6'h04;
      3'h2:    gain_d = 6'h08;
      3'h3:    gain_d = 6'h10;
      3'h4:    gain_d = 6'h20;
      3'h5:    gain_d = 6'h20;
      default: gain_d = 6'h01;
    endcase
  end

  assign track_d = on_q & (
      (~track_sel_q & (state_d != ST_CONV)) | // (R9)
      (track_sel_q & (state_d == ST_TRACK)) | // (R14)
      (track_sel_q & (start_sel_q == `SAC_START_PIN) &
       (state_d == ST_IDLE) & ~external_start_pin_i)); // (R15)

  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      converter_on_o <= 1'b0;
      track_o        <= 1'b0;
      convert_o      <= 1'b0;
      sar_tick_o     <= 1'b0;
      mux_pos_o      <= 3'h0;
      mux_neg_o      <= 3'h0;
      diff_mode_o    <= 1'b0;
      temp_sel_o     <= 1'b0;
      gain_sel_o     <= 6'h02;
    end else begin
      converter_on_o <= on_q; // (R8)
      track_o        <= track_d;
      convert_o      <= (state_d == ST_CONV);
      sar_tick_o     <= tick & (state_q == ST_CONV);
      mux_pos_o      <= pos_d;
      mux_neg_o      <= {channel_code_q[2:1], 1'b1}; // (R1)
      diff_mode_o    <= sel_diff; // (R1)
      temp_sel_o     <= channel_code_q[3]; // (R3)
      gain_sel_o     <= gain_d;
    end
  end

endmodule // sac_top
`default_nettype wire

// ### test/sac_far_end.sv
// behavioural model of the analog core feeding the block
`default_nettype none
module sac_far_end (
  input  wire logic        sys_clk_i,
  input  wire logic        convert_i,
  input  wire logic [11:0] code_i,
  input  wire logic        win_req_i,
  output logic [11:0]      conv_data_o,
  output logic             window_match_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic conv_q;
  // outside a conversion the code is scrambled, so stale capture shows
  assign conv_data_o = convert_i ? code_i : ~code_i;
  always_ff @(posedge sys_clk_i) begin
    conv_q <= convert_i;
  end
  // one match pulse just after a conversion ends
  assign window_match_o = win_req_i & conv_q & ~convert_i;
endmodule // sac_far_end
`default_nettype wire

// ### test/sac_top_properties.sv
// port assertions for the converter control block
`default_nettype none
module sac_top_properties (
  input wire logic        sys_clk_i,
  input wire logic        reset_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pready_o,
  input wire logic [31:0] prdata_o,
  input wire logic        pslverr_o,
  input wire logic        track_o,
  input wire logic        convert_o,
  input wire logic        sar_tick_o,
  input wire logic [2:0]  mux_pos_o,
  input wire logic [2:0]  mux_neg_o,
  input wire logic        diff_mode_o,
  input wire logic [5:0]  gain_sel_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // properties
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (reset_i);
  a_rdy_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready held longer than one cycle");
  a_rdy_cause: assert property (pready_o |-> psel_i && penable_i && $past(psel_i && penable_i))
    else $error("ready without a waited access");
  a_err_ready: assert property (pslverr_o |-> pready_o && prdata_o == 32'h0)
    else $error("error response malformed");
  a_rdata_upper: assert property (pready_o |-> prdata_o[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_track_excl: assert property (!(track_o && convert_o))
    else $error("tracking during conversion");
  a_gain_onehot: assert property ($onehot(gain_sel_o))
    else $error("gain select not one-hot");
  a_diff_pair: assert property (diff_mode_o |-> !mux_pos_o[0] && mux_neg_o == mux_pos_o + 3'h1)
    else $error("differential pair not even/odd");
  a_tick_conv: assert property (sar_tick_o |-> $past(convert_o))
    else $error("conversion clock outside conversion");
endmodule // sac_top_properties
bind sac_top sac_top_properties u_props (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .psel_i(psel_i),
  .penable_i(penable_i), .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
  .track_o(track_o), .convert_o(convert_o), .sar_tick_o(sar_tick_o), .mux_pos_o(mux_pos_o),
  .mux_neg_o(mux_neg_o), .diff_mode_o(diff_mode_o), .gain_sel_o(gain_sel_o));
`default_nettype wire

// ### test/tb_top.sv
// self-checking bench for the converter control block
`include "sac_defs.vh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, psel, pen, pwr, t2, t3, pin, wreq, rdy, err, lerr, on, trk, cnv, tick, dif, tmp, win;
  logic [11:0] padr, code, cdat;
  logic [31:0] pwd, prd, rd;
  logic [2:0]  mpos, mneg;
  logic [5:0]  gain;
  int          error_cnt, n_checks, ntrk, ncnv, ntk;
  logic [5:0]  gtab [8] = '{6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h20, 6'h01, 6'h01};
  sac_top dut (.sys_clk_i(clk), .reset_i(rst), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(padr), .pwdata_i(pwd), .pready_o(rdy), .prdata_o(prd), .pslverr_o(err), .timer2_ovf_i(t2),
    .timer3_ovf_i(t3), .external_start_pin_i(pin), .conv_data_i(cdat), .window_match_i(win),
    .converter_on_o(on), .track_o(trk), .convert_o(cnv), .sar_tick_o(tick), .mux_pos_o(mpos),
    .mux_neg_o(mneg), .diff_mode_o(dif), .temp_sel_o(tmp), .gain_sel_o(gain));
  sac_far_end u_far (.sys_clk_i(clk), .convert_i(cnv), .code_i(code), .win_req_i(wreq),
    .conv_data_o(cdat), .window_match_o(win));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ==========================================
  // shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    padr <= {idx, 2'b00};
    pwd <= {24'h0, d};
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (rdy !== 1'b1 && n < 40) begin
      n++;
      @(posedge clk);
    end
    rd = prd;
    lerr = err;
    psel <= 1'b0;
    pen <= 1'b0;
    if (n == 40) chk(1'b0, 1'b1);
  endtask
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask
  task automatic rdc(input logic [9:0] idx, input logic [7:0] e);
    apb(1'b0, idx, 8'h00);
    chk(rd, {24'h0, e});
  endtask
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask
  // counts tracking cycles before, and conversion cycles of, one conversion
  task automatic run_conv(input logic [7:0] ctl, input int p);
    int n;
    n = 0;
    @(posedge clk);
    pin <= 1'b0;
    wr(`SAC_IDX_CONV_CTL, ctl);
    if (ctl[3:2] != 2'h0) begin
      settle();
      chk(trk, !ctl[6] || ctl[3:2] == 2'h2);
      @(posedge clk);
      if (ctl[3:2] == 2'h1) t3 <= 1'b1; else if (ctl[3:2] == 2'h3) t2 <= 1'b1; else pin <= 1'b1;
      @(posedge clk);
      t3 <= 1'b0;
      t2 <= 1'b0;
    end
    ntrk = 0;
    ncnv = 0;
    ntk = 0;
    #1;
    while (!(ncnv > 0 && cnv === 1'b0) && n < 3000) begin
      if (trk === 1'b1 && ncnv == 0) ntrk++;
      if (cnv === 1'b1) ncnv++;
      if (tick === 1'b1) ntk++;
      n++;
      @(posedge clk);
      #1;
    end
    // the last conversion clock pulse shows in the cycle after the conversion ends
    if (tick === 1'b1) ntk++;
    chk(ncnv, 16 * p);
    chk(ntk, 16);
    chk(ntrk, (ctl[6] && ctl[3:2] != 2'h2) ? 3 * p : 0);
  endtask
  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ==========================================
  // scenarios
  task automatic test_reset();
    settle();
    chk({on, trk, cnv, gain}, 9'h002);
    rdc(`SAC_IDX_PAIR_CFG, 8'h00);
    rdc(`SAC_IDX_CHAN_SEL, 8'h00);
    rdc(`SAC_IDX_CONV_CFG, 8'hF8);
    rdc(`SAC_IDX_RES_LOW, 8'h00);
    rdc(`SAC_IDX_RES_HIGH, 8'h00);
    rdc(`SAC_IDX_CONV_CTL, 8'h00);
    $display("test reset done");
  endtask
  task automatic test_mux();
    wr(`SAC_IDX_PAIR_CFG, 8'hFF);
    rdc(`SAC_IDX_PAIR_CFG, 8'h0F);
    wr(`SAC_IDX_CHAN_SEL, 8'hFA);
    rdc(`SAC_IDX_CHAN_SEL, 8'h0A);
    chk(tmp, 1'b1);
    wr(`SAC_IDX_PAIR_CFG, 8'h04);
    wr(`SAC_IDX_CHAN_SEL, 8'h04);
    settle();
    chk({dif, tmp, mpos, mneg}, 8'hA5);
    wr(`SAC_IDX_CHAN_SEL, 8'h07);
    settle();
    chk({dif, tmp, mpos}, 5'h07);
    apb(1'b0, 10'h0BD, 8'h00);
    chk(rd, 32'h0000_0000);
    chk(lerr, 1'b1);
    for (int g = 0; g < 8; g++) begin
      wr(`SAC_IDX_CONV_CFG, 8'(g));
      settle();
      chk(gain, gtab[g]);
    end
    rdc(`SAC_IDX_CONV_CFG, 8'h07);
    $display("test mux and gain done");
  endtask
  task automatic test_sw();
    wr(`SAC_IDX_PAIR_CFG, 8'h00);
    wr(`SAC_IDX_CHAN_SEL, 8'h00);
    wr(`SAC_IDX_CONV_CFG, 8'h00);
    wr(`SAC_IDX_CONV_CTL, 8'h80);
    settle();
    chk({on, trk}, 2'h3);
    wr(`SAC_IDX_CONV_CTL, 8'h94);
    settle();
    chk(cnv, 1'b0);
    run_conv(8'h90, 1);
    rdc(`SAC_IDX_CONV_CTL, 8'hA0);
    rdc(`SAC_IDX_RES_HIGH, 8'hFA);
    rdc(`SAC_IDX_RES_LOW, 8'h5C);
    wr(`SAC_IDX_CONV_CTL, 8'h80);
    rdc(`SAC_IDX_CONV_CTL, 8'h80);
    run_conv(8'hD0, 1);
    for (int m = 1; m < 4; m++) begin
      run_conv(8'h80 | (8'(m) << 2), 1);
      run_conv(8'hC0 | (8'(m) << 2), 1);
    end
    $display("test start sources done");
  endtask
  task automatic test_diff();
    wr(`SAC_IDX_PAIR_CFG, 8'h01);
    wr(`SAC_IDX_CONV_CFG, 8'h10);
    code <= 12'h123;
    wreq <= 1'b1;
    run_conv(8'h91, 6);
    rdc(`SAC_IDX_CONV_CTL, 8'hA3);
    rdc(`SAC_IDX_RES_HIGH, 8'h92);
    rdc(`SAC_IDX_RES_LOW, 8'h30);
    wreq <= 1'b0;
    run_conv(8'h90, 6);
    rdc(`SAC_IDX_CONV_CTL, 8'hA0);
    rdc(`SAC_IDX_RES_HIGH, 8'hF9);
    rdc(`SAC_IDX_RES_LOW, 8'h23);
    $display("test differential done");
  endtask
  initial begin
    {psel, pen, pwr, t2, t3, pin, wreq, padr, pwd} = '0;
    rst = 1'b1;
    code = 12'hA5C;
    error_cnt = 0;
    n_checks = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    test_reset();
    test_mux();
    test_sw();
    test_diff();
    stop_test();
  end
  initial begin
    #200us;
    error_cnt++;
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
